// *** mfc_core.sv ***
// Summary of operation
// RULE1 - Only falling transitions of inputs A and B are counted or timed.
// RULE2 - Selections come from multiplexed inputs, meaning set by wired digit strobe.
// RULE3 - Outside wiring holds selections stable over second half of each strobe.
// RULE4 - A selection input low during a strobe means that digit is selected.
// RULE5 - Function: digit 1 freq, 8 period, 2 ratio, 5 interval, 4 unit, 3 osc.
// RULE6 - Range: digits 1 to 4 select windows of 1, 10, 100, 1000 references.
// RULE7 - Control: 4+hold off, 8 test, 2 one MHz, 1 ext osc, 3 ext dp.
// RULE8 - External dp lights the decimal point on digits sensed on its input.
// RULE9 - Main and reference sources are routed according to the function.
// RULE10 - Reference divides by 1/10/100/1000 and its output bounds the main window.
// RULE11 - Frequency counts A over a timebase gate of 0.01 to 10 s.
// RULE12 - Frequency decimal point placed for a kilohertz reading.
// RULE13 - Period counts timebase over 1 to 1000 periods of A.
// RULE14 - Ratio counts A over 1 to 1000 periods of B.
// RULE15 - Interval counts timebase from A falling to next B falling.
// RULE16 - Interval accumulates 10, 100 or 1000 A-B sequences before update.
// RULE17 - Unit mode counts A continuously and shows the running count.
// RULE18 - Oscillator mode measures the own timebase as a frequency.
// RULE19 - Window end latches main count for display, clears it, restarts.
// RULE20 - Function change aborts measurement, keeps display, starts anew.
// RULE21 - Range change outside unit mode aborts without display update.
// RULE22 - Hold stops and clears counting, or in unit mode only freezes display.
// RULE23 - Reset clears counter, stops measurement, display shows zero.
// RULE24 - One MHz select divides timebase by ten thousand for 100 Hz.
// RULE25 - A and B are synchronised and falling edges give single pulses.
// RULE26 - Selections sampled near strobe end, applied once per full scan.
`timescale 1ns/1ns
`default_nettype none
module mfc_core #(
   parameter int DIGIT_CYCLES = mfc_pkg::DIGIT_CYCLES,
   parameter int PRESCALE_10M = mfc_pkg::PRESCALE_10M,
   parameter int PRESCALE_1M  = mfc_pkg::PRESCALE_1M
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   // Measurement inputs
   input  wire logic        i_in_a,
   input  wire logic        i_in_b,
   input  wire logic        i_ext_osc,
   input  wire logic        i_hold,
   // Multiplexed selections, active low
   input  wire logic        i_func_sel_n,
   input  wire logic        i_range_sel_n,
   input  wire logic        i_ctrl_sel_n,
   input  wire logic        i_ext_dp_sel_n,
   // Scan and result
   output logic [7:0]       o_digit_strobe,
   output logic [26:0]      o_result,
   output logic             o_overflow,
   output logic [7:0]       o_dp,
   output logic             o_display_on,
   output logic             o_display_test,
   output logic             o_measuring
);
   localparam int DW = $clog2(DIGIT_CYCLES);
   localparam int PW = $clog2(PRESCALE_10M);

   logic [DW-1:0]        dig_cnt_q;
   logic [2:0]           digit_q;
   logic [7:0]           sh_func_q, sh_range_q, sh_ctrl_q, sh_xdp_q;
   mfc_pkg::mfc_func_t   func_q, func_d;
   logic [1:0]           range_q, range_d;
   logic                 mhz1_q, extosc_q, xdp_q, test_q, off_q;
   logic [7:0]           xdp_dig_q;
   logic [2:0]           s1_q, s2_q, s3_q;
   logic [2:0]           fall_w;
   logic                 osc_tick, tick100;
   logic [PW-1:0]        presc_q;
   mfc_pkg::mfc_state_t  state_q;
   logic [9:0]           ref_cnt_q;
   logic [26:0]          main_q;
   logic                 ovf_q;
   logic [26:0]          main_inc;
   logic                 cnt_en, ovf_inc;
   logic                 sample_w, commit_w, abort_w, restart_w, done_w;
   logic                 start_evt, ref_evt, main_evt;
   logic [3:0]           dp_idx;
   logic [7:0]           dp_d;

   // ==========================================
   // Digit scan
   assign sample_w = dig_cnt_q == DW'(DIGIT_CYCLES - 1 - mfc_pkg::SAMPLE_LEAD);
   assign commit_w = dig_cnt_q == DW'(DIGIT_CYCLES - 1) && digit_q == 3'(mfc_pkg::NDIG - 1);

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         dig_cnt_q      <= '0;
         digit_q        <= '0;
         o_digit_strobe <= mfc_pkg::STROBE_RST;
      end
      else if (dig_cnt_q == DW'(DIGIT_CYCLES - 1))
      begin
         dig_cnt_q      <= '0;
         digit_q        <= digit_q + 3'h1;
         o_digit_strobe <= {o_digit_strobe[6:0], o_digit_strobe[7]};
      end
      else
         dig_cnt_q <= dig_cnt_q + DW'(1);
   end

   // RULE3 sample late in strobe
   // Sampling two cycles before the strobe ends keeps clear of the settling first half.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sh_func_q  <= '0;
         sh_range_q <= '0;
         sh_ctrl_q  <= '0;
         sh_xdp_q   <= '0;
      end
      else if (sample_w)
      begin
         // RULE4 low means selected
         sh_func_q[digit_q]  <= !i_func_sel_n;
         sh_range_q[digit_q] <= !i_range_sel_n;
         sh_ctrl_q[digit_q]  <= !i_ctrl_sel_n;
         sh_xdp_q[digit_q]   <= !i_ext_dp_sel_n;
      end
   end

   // RULE5 function decode
   always_comb
   begin
      func_d = func_q;
      if (sh_func_q[mfc_pkg::FUNC_FREQ_DIG])       func_d = mfc_pkg::MFC_FREQ;
      else if (sh_func_q[mfc_pkg::FUNC_PER_DIG])   func_d = mfc_pkg::MFC_PERIOD;
      else if (sh_func_q[mfc_pkg::FUNC_RATIO_DIG]) func_d = mfc_pkg::MFC_RATIO;
      else if (sh_func_q[mfc_pkg::FUNC_INT_DIG])   func_d = mfc_pkg::MFC_INTERVAL;
      else if (sh_func_q[mfc_pkg::FUNC_UNIT_DIG])  func_d = mfc_pkg::MFC_UNIT;
      else if (sh_func_q[mfc_pkg::FUNC_OSC_DIG])   func_d = mfc_pkg::MFC_OSC;
   end

   // RULE6 range decode
   always_comb
   begin
      range_d = range_q;
      if (sh_range_q[0])      range_d = 2'h0;
      else if (sh_range_q[1]) range_d = 2'h1;
      else if (sh_range_q[2]) range_d = 2'h2;
      else if (sh_range_q[3]) range_d = 2'h3;
   end

   // RULE2 RULE26 apply once per scan
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         func_q    <= mfc_pkg::MFC_FREQ;
         range_q   <= mfc_pkg::RANGE_RST;
         mhz1_q    <= 1'b0;
         extosc_q  <= 1'b0;
         xdp_q     <= 1'b0;
         test_q    <= 1'b0;
         off_q     <= 1'b0;
         xdp_dig_q <= '0;
      end
      else if (commit_w)
      begin
         func_q    <= func_d;
         range_q   <= range_d;
         // RULE7 control decode
         mhz1_q    <= sh_ctrl_q[mfc_pkg::CTRL_1M_DIG];
         extosc_q  <= sh_ctrl_q[mfc_pkg::CTRL_EXTOSC_DIG];
         xdp_q     <= sh_ctrl_q[mfc_pkg::CTRL_XDP_DIG];
         test_q    <= sh_ctrl_q[mfc_pkg::CTRL_TEST_DIG];
         off_q     <= sh_ctrl_q[mfc_pkg::CTRL_OFF_DIG];
         xdp_dig_q <= sh_xdp_q;
      end
   end

   // ==========================================
   // Input edges and timebase
   // RULE25 sync and edge detect
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= {i_ext_osc, i_in_b, i_in_a};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // RULE1 falling edges only
   assign fall_w   = s3_q & ~s2_q;
   // External timebase must be well below the core clock
   assign osc_tick = extosc_q ? fall_w[2] : 1'b1;

   // RULE24 prescaler length
   assign tick100 = osc_tick && presc_q == (mhz1_q ? PW'(PRESCALE_1M - 1) : PW'(PRESCALE_10M - 1));
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         presc_q <= '0;
      else if (tick100)
         presc_q <= '0;
      else if (osc_tick)
         presc_q <= presc_q + PW'(1);
   end

   // ==========================================
   // Routing
   // RULE9 RULE11 RULE13 RULE14 RULE18 source routing
   always_comb
   begin
      start_evt = 1'b0;
      ref_evt   = 1'b0;
      main_evt  = osc_tick;
      case (func_q)
         mfc_pkg::MFC_FREQ, mfc_pkg::MFC_OSC:
         begin
            start_evt = tick100;
            ref_evt   = tick100;
            main_evt  = (func_q == mfc_pkg::MFC_FREQ) ? fall_w[0] : osc_tick;
         end
         mfc_pkg::MFC_PERIOD:
         begin
            start_evt = fall_w[0];
            ref_evt   = fall_w[0];
         end
         mfc_pkg::MFC_RATIO:
         begin
            start_evt = fall_w[1];
            ref_evt   = fall_w[1];
            main_evt  = fall_w[0];
         end
         // RULE15 A starts, B stops
         mfc_pkg::MFC_INTERVAL:
         begin
            start_evt = fall_w[0];
            ref_evt   = fall_w[1];
         end
         mfc_pkg::MFC_UNIT:
            main_evt = fall_w[0];
         default:
            main_evt = 1'b0;
      endcase
   end

   // ==========================================
   // Measurement sequencing
   // RULE20 RULE21 abort on function or range change
   assign abort_w   = commit_w && (func_d != func_q ||
                      (range_d != range_q && func_d != mfc_pkg::MFC_UNIT));
   // RULE22 hold restarts outside unit mode
   assign restart_w = abort_w || (i_hold && func_q != mfc_pkg::MFC_UNIT);
   // RULE10 window ends after N references
   assign done_w    = state_q == mfc_pkg::MFC_GATE && ref_evt &&
                      ref_cnt_q == mfc_pkg::ref_limit(range_q) - 10'h001;

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q   <= mfc_pkg::MFC_ARM;
         ref_cnt_q <= '0;
      end
      else if (restart_w || func_q == mfc_pkg::MFC_UNIT)
      begin
         state_q   <= mfc_pkg::MFC_ARM;
         ref_cnt_q <= '0;
      end
      else
         case (state_q)
            mfc_pkg::MFC_ARM:
               if (start_evt)
                  state_q <= mfc_pkg::MFC_GATE;
            mfc_pkg::MFC_GATE:
               if (done_w)
               begin
                  state_q   <= mfc_pkg::MFC_ARM;
                  ref_cnt_q <= '0;
               end
               else if (ref_evt)
               begin
                  ref_cnt_q <= ref_cnt_q + 10'h001;
                  // RULE16 rearm for next sequence
                  if (func_q == mfc_pkg::MFC_INTERVAL)
                     state_q <= mfc_pkg::MFC_ARM;
               end
            default:
               state_q <= mfc_pkg::MFC_ARM;
         endcase
   end

   // RULE23 RULE19 main counter
   // Saturating at the top keeps overflow sticky until the next window.
   // An event on the closing edge still belongs to the window, so no count is lost.
   // RULE17 unit always enabled
   assign cnt_en   = main_evt &&
                     (func_q == mfc_pkg::MFC_UNIT || state_q == mfc_pkg::MFC_GATE);
   assign main_inc = (cnt_en && main_q != mfc_pkg::RESULT_MAX) ? main_q + 27'h1 : main_q;
   assign ovf_inc  = ovf_q || (cnt_en && main_q == mfc_pkg::RESULT_MAX);

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         main_q <= mfc_pkg::RESULT_RST;
         ovf_q  <= 1'b0;
      end
      else if (restart_w || done_w)
      begin
         main_q <= mfc_pkg::RESULT_RST;
         ovf_q  <= 1'b0;
      end
      else
      begin
         main_q <= main_inc;
         ovf_q  <= ovf_inc;
      end
   end

   // RULE19 RULE22 display latches
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_result   <= mfc_pkg::RESULT_RST;
         o_overflow <= 1'b0;
      end
      else if (func_q == mfc_pkg::MFC_UNIT)
      begin
         if (!i_hold)
         begin
            o_result   <= main_q;
            o_overflow <= ovf_q;
         end
      end
      else if (done_w && !restart_w)
      begin
         o_result   <= main_inc;
         o_overflow <= ovf_inc;
      end
   end

   // ==========================================
   // Display qualifiers
   // RULE12 RULE24 decimal point placement
   always_comb
   begin
      case (func_q)
         mfc_pkg::MFC_RATIO: dp_idx = {2'h0, range_q};
         mfc_pkg::MFC_UNIT:  dp_idx = 4'h0;
         default:            dp_idx = {2'h0, range_q} + 4'h1;
      endcase
      if (mhz1_q && (func_q == mfc_pkg::MFC_PERIOD || func_q == mfc_pkg::MFC_INTERVAL))
         dp_idx = dp_idx - 4'h1;
      dp_d = 8'h01 << dp_idx;
      // RULE8 external decimal point
      if (xdp_q)
         dp_d = xdp_dig_q;
      dp_d[mfc_pkg::OVF_DIG] = dp_d[mfc_pkg::OVF_DIG] | o_overflow;
      if (test_q)
         dp_d = 8'hFF;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_dp           <= 8'h00;
         o_display_on   <= 1'b1;
         o_display_test <= 1'b0;
         o_measuring    <= 1'b0;
      end
      else
      begin
         o_dp           <= dp_d;
         o_display_on   <= !(off_q && i_hold);
         o_display_test <= test_q && !(off_q && i_hold);
         o_measuring    <= state_q == mfc_pkg::MFC_GATE;
      end
   end

   // ==========================================
   // Checks
   scan_onehot_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      $onehot(o_digit_strobe)) else $error("digit strobe not one-hot");
   func_abort_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE20
      abort_w && func_q != mfc_pkg::MFC_UNIT |=> main_q == 27'h0 && o_result == $past(o_result))
      else $error("function change did not abort cleanly");
   range_abort_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE21
      commit_w && range_d != range_q && func_d != mfc_pkg::MFC_UNIT
      |=> state_q == mfc_pkg::MFC_ARM) else $error("range change did not rearm");
   hold_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE22
      i_hold && func_q != mfc_pkg::MFC_UNIT |=> main_q == 27'h0 ##1 !o_measuring)
      else $error("hold did not stop counting");
   unit_freeze_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE22
      i_hold && func_q == mfc_pkg::MFC_UNIT && $past(i_hold) |-> $stable(o_result))
      else $error("unit display not frozen");
   latch_end_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE19
      done_w && !restart_w |=> o_result == $past(main_inc) && main_q == 27'h0)
      else $error("window end did not latch");
   unit_count_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE17
      func_q == mfc_pkg::MFC_UNIT && main_evt && !restart_w && main_q != mfc_pkg::RESULT_MAX
      |=> main_q == $past(main_q) + 27'h1) else $error("unit count missed");
   edge_single_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE25
      fall_w[0] |=> !fall_w[0] ##1 !fall_w[0]) else $error("edge pulse repeated");
   freq_done_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      done_w && func_q == mfc_pkg::MFC_FREQ);
   int_done_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      done_w && func_q == mfc_pkg::MFC_INTERVAL && range_q != 2'h0);
   unit_hold_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      func_q == mfc_pkg::MFC_UNIT && i_hold && main_evt);
   abort_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      abort_w && state_q == mfc_pkg::MFC_GATE);
endmodule
`default_nettype wire

// *** mfc_pkg.sv ***
`default_nettype none
package mfc_pkg;
   // ==========================================
   // Types
   typedef enum logic [2:0] {
      MFC_FREQ, MFC_PERIOD, MFC_RATIO, MFC_INTERVAL, MFC_UNIT, MFC_OSC
   } mfc_func_t;
   typedef enum logic {MFC_ARM, MFC_GATE} mfc_state_t;

   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS   = 20;
   // Eight digits scanned at 500 Hz
   localparam int DIGIT_PERIOD_NS = 250000;
   localparam int DIGIT_CYCLES    = DIGIT_PERIOD_NS / CLK_PERIOD_NS;
   // Cycles before strobe end where selections are sampled
   localparam int SAMPLE_LEAD     = 2;
   localparam int PRESCALE_10M    = 100000;
   localparam int PRESCALE_1M     = 10000;

   // ==========================================
   // Digit positions, digit one is bit 0
   localparam int NDIG            = 8;
   localparam int FUNC_FREQ_DIG   = 0;
   localparam int FUNC_RATIO_DIG  = 1;
   localparam int FUNC_OSC_DIG    = 2;
   localparam int FUNC_UNIT_DIG   = 3;
   localparam int FUNC_INT_DIG    = 4;
   localparam int FUNC_PER_DIG    = 7;
   localparam int CTRL_EXTOSC_DIG = 0;
   localparam int CTRL_1M_DIG     = 1;
   localparam int CTRL_XDP_DIG    = 2;
   localparam int CTRL_OFF_DIG    = 3;
   localparam int CTRL_TEST_DIG   = 7;
   localparam int OVF_DIG         = 7;

   // ==========================================
   // Counter and reset values
   localparam int        RESULT_W   = 27;
   localparam logic [26:0] RESULT_MAX = 27'h5F5E0FF;
   localparam logic [26:0] RESULT_RST = 27'h0000000;
   localparam logic [1:0]  RANGE_RST  = 2'h0;
   localparam logic [7:0]  STROBE_RST = 8'h01;

   // Reference division per range: 1, 10, 100, 1000
   function automatic logic [9:0] ref_limit(input logic [1:0] rng);
      case (rng)
         2'h0:    ref_limit = 10'h001;
         2'h1:    ref_limit = 10'h00A;
         2'h2:    ref_limit = 10'h064;
         default: ref_limit = 10'h3E8;
      endcase
   endfunction
endpackage
`default_nettype wire

// *** mfc_stim_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mfc_stim_model (
   // Clock and scan
   input  wire logic        i_core_clk,
   input  wire logic [7:0]  i_digit_strobe,
   // Wiring, one bit per digit
   input  wire logic [7:0]  i_func_mask,
   input  wire logic [7:0]  i_range_mask,
   input  wire logic [7:0]  i_ctrl_mask,
   input  wire logic [7:0]  i_dp_mask,
   // Source periods in clock cycles, zero holds the line high
   input  wire logic [11:0] i_per_a,
   input  wire logic [11:0] i_per_b,
   input  wire logic [11:0] i_ofs_b,
   // Pins towards the core
   output logic             o_in_a,
   output logic             o_in_b,
   output logic             o_ext_osc,
   output logic             o_func_sel_n,
   output logic             o_range_sel_n,
   output logic             o_ctrl_sel_n,
   output logic             o_ext_dp_sel_n
);
   logic [31:0] cnt_q = 32'h00000000;

   // ==========================================
   // Diode wiring
   // stable whole digit
   // Strobe is registered, so each level holds for the full digit, not just its last half
   assign o_func_sel_n   = ~|(i_digit_strobe & i_func_mask);
   assign o_range_sel_n  = ~|(i_digit_strobe & i_range_mask);
   assign o_ctrl_sel_n   = ~|(i_digit_strobe & i_ctrl_mask);
   assign o_ext_dp_sel_n = ~|(i_digit_strobe & i_dp_mask);

   // ==========================================
   // Pulse sources
   // One free counter keeps A and B phase-locked, which makes interval results exact
   always_ff @(posedge i_core_clk)
   begin
      cnt_q     <= cnt_q + 32'h1;
      o_in_a    <= (i_per_a == 12'h000) || ((cnt_q % 32'(i_per_a)) < 32'(i_per_a / 2));
      o_in_b    <= (i_per_b == 12'h000) ||
                   (((cnt_q + 32'(i_per_b) - 32'(i_ofs_b)) % 32'(i_per_b)) < 32'(i_per_b / 2));
      o_ext_osc <= cnt_q[1];
   end
endmodule
`default_nettype wire

// *** mfc_core_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module mfc_core_tb_top;
   logic        i_core_clk = 1'b0;
   logic        i_rst_n    = 1'b0;
   logic        i_hold     = 1'b0;
   logic [7:0]  fm = 8'h01, rm = 8'h01, cm = 8'h00, dm = 8'h00;
   logic [11:0] pa = 12'h000, pb = 12'h000, ob = 12'h000;
   logic        in_a, in_b, ext_osc, func_n, range_n, ctrl_n, dp_n;
   logic [7:0]  o_digit_strobe;
   logic [26:0] o_result;
   logic        o_overflow;
   logic [7:0]  o_dp;
   logic        o_display_on;
   logic        o_display_test;
   logic        o_measuring;
   logic [26:0] snap;
   int          err_count = 0;
   int          checks = 0;

   // ==========================================
   // Clock and instances
   initial
   begin
      forever #10 i_core_clk = ~i_core_clk;
   end

   mfc_core #(.DIGIT_CYCLES(16), .PRESCALE_10M(40), .PRESCALE_1M(8)) u_mfc_core (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_in_a(in_a), .i_in_b(in_b),
      .i_ext_osc(ext_osc), .i_hold(i_hold), .i_func_sel_n(func_n),
      .i_range_sel_n(range_n), .i_ctrl_sel_n(ctrl_n), .i_ext_dp_sel_n(dp_n),
      .o_digit_strobe(o_digit_strobe), .o_result(o_result), .o_overflow(o_overflow),
      .o_dp(o_dp), .o_display_on(o_display_on), .o_display_test(o_display_test),
      .o_measuring(o_measuring));

   mfc_stim_model u_mfc_stim_model (
      .i_core_clk(i_core_clk), .i_digit_strobe(o_digit_strobe), .i_func_mask(fm),
      .i_range_mask(rm), .i_ctrl_mask(cm), .i_dp_mask(dm), .i_per_a(pa), .i_per_b(pb),
      .i_ofs_b(ob), .o_in_a(in_a), .o_in_b(in_b), .o_ext_osc(ext_osc),
      .o_func_sel_n(func_n), .o_range_sel_n(range_n), .o_ctrl_sel_n(ctrl_n),
      .o_ext_dp_sel_n(dp_n));

   // ==========================================
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // Masks change just after a commit, so the next scan carries only new settings
   // and the caller looks right after they apply, before a new window can end
   task automatic setup(input logic [7:0] f, r, c, d, input logic [11:0] a, b, o);
      while (o_digit_strobe !== 8'h80)
         tick(1);
      while (o_digit_strobe !== 8'h01)
         tick(1);
      @(posedge i_core_clk);
      fm <= f;
      rm <= r;
      cm <= c;
      dm <= d;
      pa <= a;
      pb <= b;
      ob <= o;
      tick(130);
   endtask

   task automatic wait_end();
      int  n;
      logic prev;
      n = 0;
      prev = 1'b0;
      while (n < 6000 && !(prev === 1'b1 && o_measuring === 1'b0))
      begin
         prev = o_measuring;
         tick(1);
         n++;
      end
      if (n >= 6000)
      begin
         err_count++;
         $display("[FAIL] window end not seen");
      end
   endtask

   // First window after a change is discarded, the second must be exact
   task automatic measure(input string name, input logic [26:0] exp, input logic [7:0] dp);
      wait_end();
      wait_end();
      tick(1);
      check(name, o_result, exp);
      check({name, "_dp"}, o_dp, dp);
      $display("test %s done", name);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================
   // Watchdog, about nine times the expected run
   initial
   begin
      tick(90000);
      err_count++;
      $display("[FAIL] watchdog expired");
      print_verdict();
   end

   // ==========================================
   // Tests
   initial
   begin
      tick(8);
      check("rst_result", o_result, 0);
      check("rst_measuring", o_measuring, 0);
      check("rst_strobe", o_digit_strobe, 8'h01);
      @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      tick(17);
      check("scan_step", o_digit_strobe, 8'h02);
      $display("test reset done");
      setup(8'h01, 8'h01, 8'h00, 8'h00, 12'd4, 12'd0, 12'd0);
      measure("freq_r0", 27'd10, 8'h02);
      setup(8'h01, 8'h02, 8'h00, 8'h00, 12'd4, 12'd0, 12'd0);
      measure("freq_r1", 27'd100, 8'h04);
      setup(8'h01, 8'h01, 8'h00, 8'h00, 12'd4, 12'd0, 12'd0);
      check("range_abort", o_result, 27'd100);
      measure("freq_back", 27'd10, 8'h02);
      setup(8'h01, 8'h02, 8'h00, 8'h00, 12'd4, 12'd0, 12'd0);
      measure("freq_again", 27'd100, 8'h04);
      setup(8'h04, 8'h02, 8'h00, 8'h00, 12'd4, 12'd0, 12'd0);
      check("func_abort", o_result, 27'd100);
      measure("osc_r1", 27'd400, 8'h04);
      setup(8'h04, 8'h01, 8'h01, 8'h00, 12'd0, 12'd0, 12'd0);
      measure("osc_ext", 27'd40, 8'h02);
      setup(8'h01, 8'h01, 8'h02, 8'h00, 12'd4, 12'd0, 12'd0);
      measure("freq_1m", 27'd2, 8'h02);
      setup(8'h80, 8'h01, 8'h00, 8'h00, 12'd20, 12'd0, 12'd0);
      measure("period_r0", 27'd20, 8'h02);
      setup(8'h80, 8'h01, 8'h02, 8'h00, 12'd20, 12'd0, 12'd0);
      measure("period_1m", 27'd20, 8'h01);
      setup(8'h02, 8'h02, 8'h00, 8'h00, 12'd4, 12'd40, 12'd0);
      measure("ratio_r1", 27'd100, 8'h02);
      setup(8'h10, 8'h01, 8'h00, 8'h00, 12'd40, 12'd40, 12'd10);
      measure("intv_r0", 27'd10, 8'h02);
      setup(8'h10, 8'h02, 8'h00, 8'h00, 12'd40, 12'd40, 12'd10);
      // Every A-B sequence drops o_measuring, so let one whole window pass first
      repeat (10) wait_end();
      measure("intv_r1", 27'd100, 8'h04);
      setup(8'h01, 8'h01, 8'h00, 8'h00, 12'd4, 12'd0, 12'd0);
      measure("freq_prehold", 27'd10, 8'h02);
      @(posedge i_core_clk);
      i_hold <= 1'b1;
      tick(3);
      check("hold_stop", o_measuring, 0);
      tick(200);
      check("hold_keep", o_result, 27'd10);
      @(posedge i_core_clk);
      i_hold <= 1'b0;
      measure("freq_after_hold", 27'd10, 8'h02);
      setup(8'h08, 8'h01, 8'h00, 8'h00, 12'd10, 12'd0, 12'd0);
      check("unit_dp", o_dp, 8'h01);
      @(posedge i_core_clk);
      i_hold <= 1'b1;
      tick(3);
      snap = o_result;
      tick(100);
      check("unit_freeze", o_result, snap);
      @(posedge i_core_clk);
      i_hold <= 1'b0;
      tick(100);
      check("unit_runs", o_result > snap + 27'd15, 1);
      $display("test unit done");
      setup(8'h01, 8'h01, 8'h80, 8'h00, 12'd4, 12'd0, 12'd0);
      check("disp_test", o_display_test, 1);
      setup(8'h01, 8'h01, 8'h04, 8'h20, 12'd4, 12'd0, 12'd0);
      check("ext_dp", o_dp[5], 1);
      setup(8'h01, 8'h01, 8'h08, 8'h00, 12'd4, 12'd0, 12'd0);
      check("disp_on_nohold", o_display_on, 1);
      @(posedge i_core_clk);
      i_hold <= 1'b1;
      tick(300);
      check("disp_off", o_display_on, 0);
      @(posedge i_core_clk);
      i_hold <= 1'b0;
      $display("test control done");
      setup(8'h01, 8'h01, 8'h00, 8'h00, 12'd4, 12'd0, 12'd0);
      measure("freq_prereset", 27'd10, 8'h02);
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      tick(2);
      check("reset_clear", o_result, 0);
      check("reset_stop", o_measuring, 0);
      check("reset_ovf", o_overflow, 0);
      $display("test reset again done");
      print_verdict();
   end
endmodule
`default_nettype wire
